/* logic/ow_dim_pkg.sv */
// Purpose: Constants for the single-wire dimming command receiver
// Assumes: 50 MHz system clock
// Notes:   Times are given in ns; cycle counts are derived from them
package ow_dim_pkg;
  localparam int unsigned CLK_PERIOD_NS        = 20;
  localparam int unsigned END_OF_STREAM_NS     = 3500;
  localparam int unsigned ACK_DELAY_NS         = 3500;
  localparam int unsigned ACK_PULSE_MAX_NS     = 900000;
  // Least times round up, longest time rounds down
  localparam int unsigned EOS_CYCLES       = (END_OF_STREAM_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned ACK_DELAY_CYCLES = (ACK_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned ACK_PULSE_CYCLES = ACK_PULSE_MAX_NS / CLK_PERIOD_NS;
  // Longest bit at 1.1 kbit/s is about 45455 cycles; 17 bits of count suffice
  localparam int unsigned CNT_W            = 17;
  localparam int unsigned BYTE_BITS        = 8;
  localparam int unsigned ACK_FLAG_POS     = 7;
  localparam int unsigned SUBADDR_HI_POS   = 6;
  localparam int unsigned SUBADDR_LO_POS   = 5;
  localparam int unsigned LEVEL_W          = 5;
  localparam logic [4:0]  LEVEL_RESET      = 5'h00;
  // Arbitrary device address; bit 0 is zero as the protocol demands
  localparam logic [7:0]  DEVICE_ADDR_DEFAULT = 8'hA4;
endpackage : ow_dim_pkg

/* logic/bit_ratio_decoder.sv */
// Purpose: Measures one bit period between falling edges and classifies it
// Assumes: Line input already synchronised to sys_clk_i
// Notes:   Counters saturate; a period with no clear 2:1 ratio is flagged bad
`timescale 1ns/1ps
`default_nettype none
module bit_ratio_decoder
  import ow_dim_pkg::*;
(
  input  wire logic sys_clk_i,
  input  wire logic rstn_i,
  input  wire logic line_i,
  input  wire logic fall_i,
  input  wire logic clear_i,
  output logic      bit_valid_o,
  output logic      bit_value_o,
  output logic      bit_bad_o
);
  logic [CNT_W-1:0] low_cnt_reg;
  logic [CNT_W-1:0] high_cnt_reg;
  logic             active_reg;
  wire  logic       low_sat  = &low_cnt_reg;
  wire  logic       high_sat = &high_cnt_reg;
  wire  logic [CNT_W:0] low_x2  = {low_cnt_reg, 1'b0};
  wire  logic [CNT_W:0] high_x2 = {high_cnt_reg, 1'b0};
  wire  logic       is_zero = ({1'b0, low_cnt_reg} >= high_x2) && (high_cnt_reg != '0);
  wire  logic       is_one  = ({1'b0, high_cnt_reg} >= low_x2) && (low_cnt_reg != '0);

  always_ff @(posedge sys_clk_i) begin
    if (!rstn_i || clear_i) begin
      low_cnt_reg  <= '0;
      high_cnt_reg <= '0;
      active_reg   <= 1'b0;
      bit_valid_o  <= 1'b0;
      bit_value_o  <= 1'b0;
      bit_bad_o    <= 1'b0;
    end else begin
      bit_valid_o <= 1'b0;
      bit_bad_o   <= 1'b0;
      if (fall_i) begin
        // Classification only at the closing falling edge
        if (active_reg) begin
          bit_valid_o <= is_zero || is_one;
          bit_bad_o   <= !(is_zero || is_one);
          bit_value_o <= is_one;
        end
        active_reg   <= 1'b1;
        low_cnt_reg  <= '0;
        high_cnt_reg <= '0;
      end else if (active_reg) begin
        if (!line_i && !low_sat)
          low_cnt_reg <= low_cnt_reg + 1'b1;
        if (line_i && !high_sat)
          high_cnt_reg <= high_cnt_reg + 1'b1;
      end
    end
  end
endmodule : bit_ratio_decoder
`default_nettype wire

/* logic/ow_dim_receiver.sv */
// Purpose: Single-wire address/data command receiver with open-drain acknowledge
// Assumes: Host pulls the line high; line_i is asynchronous to sys_clk_i
// Notes:   Bytes are framed by counting eight bits, then a long low
`timescale 1ns/1ps
`default_nettype none
module ow_dim_receiver
  import ow_dim_pkg::*;
#(
  parameter logic [7:0] DEVICE_ADDR = DEVICE_ADDR_DEFAULT
)(
  input  wire logic              sys_clk_i,
  input  wire logic              rstn_i,
  input  wire logic              line_i,
  output logic                   line_o,
  output logic                   line_oe_o,
  output logic [LEVEL_W-1:0]     feedback_reference_o,
  output logic                   level_update_o,
  output logic                   frame_error_o
);
  typedef enum logic [2:0] {
    ST_ADDR  = 3'b000,
    ST_DATA  = 3'b001,
    ST_DELAY = 3'b011,
    ST_ACK   = 3'b010,
    ST_WAIT  = 3'b110
  } rx_state_t;

  rx_state_t        state_reg, state_next;
  logic             sync1_reg, sync2_reg, prev_reg;
  logic [7:0]       shift_reg;
  logic [3:0]       nbits_reg;
  logic [7:0]       addr_reg;
  logic             bad_reg;
  logic [CNT_W-1:0] low_run_reg;
  logic [CNT_W-1:0] oe_run_reg;
  logic [CNT_W-1:0] timer_reg;
  logic             bit_valid, bit_value, bit_bad;

  wire logic fall     = prev_reg && !sync2_reg;
  // A high of start length also occurs inside a 1 bit, so bytes are framed by bit count
  wire logic eos_hit  = !sync2_reg && (nbits_reg == 4'(BYTE_BITS))
                        && (low_run_reg == CNT_W'(EOS_CYCLES - 1));
  wire logic byte_ok  = (nbits_reg == 4'(BYTE_BITS)) && !bad_reg;
  wire logic [7:0] shift_next = {shift_reg[6:0], bit_value};
  wire logic addr_match = (addr_reg == DEVICE_ADDR);
  wire logic data_ok  = byte_ok && addr_match && !shift_reg[SUBADDR_HI_POS]
                        && !shift_reg[SUBADDR_LO_POS];
  wire logic want_ack = data_ok && shift_reg[ACK_FLAG_POS];
  // Delay counted from the last falling edge, that edge being the close of D0
  wire logic delay_done = timer_reg >= CNT_W'(ACK_DELAY_CYCLES - 1);
  wire logic pulse_done = timer_reg == CNT_W'(ACK_PULSE_CYCLES - 1);
  wire logic decoder_clear = (state_reg == ST_ACK) || (state_reg == ST_WAIT);

  bit_ratio_decoder u_dec (
    .sys_clk_i   (sys_clk_i),
    .rstn_i      (rstn_i),
    .line_i      (sync2_reg),
    .fall_i      (fall),
    .clear_i     (decoder_clear || eos_hit),
    .bit_valid_o (bit_valid),
    .bit_value_o (bit_value),
    .bit_bad_o   (bit_bad)
  );

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ST_ADDR:  if (eos_hit) state_next = byte_ok ? ST_DATA : ST_ADDR;
      ST_DATA:  if (eos_hit) state_next = want_ack ? ST_DELAY : ST_ADDR;
      ST_DELAY: if (delay_done) state_next = ST_ACK;
      ST_ACK:   if (pulse_done) state_next = ST_WAIT;
      ST_WAIT:  if (sync2_reg) state_next = ST_ADDR;
      default:  state_next = ST_ADDR;
    endcase
  end

  always_ff @(posedge sys_clk_i) begin
    if (!rstn_i) begin
      sync1_reg <= 1'b1;
      sync2_reg <= 1'b1;
      prev_reg  <= 1'b1;
    end else begin
      sync1_reg <= line_i;
      sync2_reg <= sync1_reg;
      prev_reg  <= sync2_reg;
    end
  end

  // Low-run counter: end-of-stream low after the closing edge of the eighth bit
  always_ff @(posedge sys_clk_i) begin
    if (!rstn_i || sync2_reg)
      low_run_reg <= '0;
    else if (low_run_reg != CNT_W'(EOS_CYCLES))
      low_run_reg <= low_run_reg + 1'b1;
  end

  always_ff @(posedge sys_clk_i) begin
    if (!rstn_i || eos_hit || decoder_clear) begin
      shift_reg <= shift_reg;
      nbits_reg <= '0;
      bad_reg   <= 1'b0;
      if (!rstn_i) shift_reg <= 8'h00;
    end else if (bit_valid || bit_bad) begin
      shift_reg <= shift_next;
      bad_reg   <= bad_reg || bit_bad || (nbits_reg == 4'(BYTE_BITS));
      if (nbits_reg != 4'(BYTE_BITS)) nbits_reg <= nbits_reg + 1'b1;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (!rstn_i) begin
      state_reg            <= ST_ADDR;
      addr_reg             <= 8'h00;
      timer_reg            <= '0;
      feedback_reference_o <= LEVEL_RESET;
      level_update_o       <= 1'b0;
      frame_error_o        <= 1'b0;
    end else begin
      state_reg      <= state_next;
      level_update_o <= 1'b0;
      frame_error_o  <= 1'b0;
      if (state_reg == ST_ADDR && eos_hit) begin
        addr_reg      <= shift_reg;
        frame_error_o <= !byte_ok && (nbits_reg != '0);
      end
      if (state_reg == ST_DATA && eos_hit) begin
        frame_error_o <= !data_ok;
        if (data_ok) begin
          feedback_reference_o <= shift_reg[LEVEL_W-1:0];
          level_update_o       <= 1'b1;
        end
        timer_reg <= CNT_W'(EOS_CYCLES);
      end else if (state_reg != state_next)
        timer_reg <= '0;
      else
        timer_reg <= timer_reg + 1'b1;
    end
  end

  // Open drain: only ever drives low
  assign line_o    = 1'b0;
  assign line_oe_o = (state_reg == ST_ACK);

  // Pulse length is far too long for a repetition, so it is counted here
  always_ff @(posedge sys_clk_i) begin
    if (!rstn_i || !line_oe_o)
      oe_run_reg <= '0;
    else if (oe_run_reg != CNT_W'(ACK_PULSE_CYCLES))
      oe_run_reg <= oe_run_reg + 1'b1;
  end

  property p_ack_len;
    @(posedge sys_clk_i) disable iff (!rstn_i)
      $fell(line_oe_o) |-> $past(oe_run_reg) == CNT_W'(ACK_PULSE_CYCLES - 1);
  endproperty
  a_ack_len: assert property (p_ack_len) else $error("ack pulse length wrong");

  property p_ack_max;
    @(posedge sys_clk_i) disable iff (!rstn_i)
      line_oe_o |-> oe_run_reg < CNT_W'(ACK_PULSE_CYCLES);
  endproperty
  a_ack_max: assert property (p_ack_max) else $error("ack pulse too long");

  property p_ack_cause;
    @(posedge sys_clk_i) disable iff (!rstn_i)
      $rose(line_oe_o) |-> $past(state_reg) == ST_DELAY;
  endproperty
  a_ack_cause: assert property (p_ack_cause) else $error("ack without delay");

  property p_delay_time;
    @(posedge sys_clk_i) disable iff (!rstn_i)
      (state_reg == ST_DATA && state_next == ST_DELAY) |-> ##[1:180] line_oe_o;
  endproperty
  a_delay_time: assert property (p_delay_time) else $error("ack delay too long");

  property p_no_ack_mismatch;
    @(posedge sys_clk_i) disable iff (!rstn_i)
      (state_reg == ST_DATA && eos_hit && !addr_match) |=> state_reg == ST_ADDR;
  endproperty
  a_no_ack_mismatch: assert property (p_no_ack_mismatch) else $error("ack on mismatch");

  property p_level_hold;
    @(posedge sys_clk_i) disable iff (!rstn_i)
      !level_update_o |-> $stable(feedback_reference_o);
  endproperty
  a_level_hold: assert property (p_level_hold) else $error("level changed");

  property p_flag;
    @(posedge sys_clk_i) disable iff (!rstn_i)
      (state_reg == ST_DATA && eos_hit && data_ok && !shift_reg[ACK_FLAG_POS])
        |=> state_reg == ST_ADDR;
  endproperty
  a_flag: assert property (p_flag) else $error("ack without request");

  property p_subaddr;
    @(posedge sys_clk_i) disable iff (!rstn_i)
      (state_reg == ST_DATA && eos_hit
        && (shift_reg[SUBADDR_HI_POS] || shift_reg[SUBADDR_LO_POS])) |=> !level_update_o;
  endproperty
  a_subaddr: assert property (p_subaddr) else $error("bad subaddress taken");

  property p_bit_at_edge;
    @(posedge sys_clk_i) disable iff (!rstn_i)
      bit_valid |-> $past(fall);
  endproperty
  a_bit_at_edge: assert property (p_bit_at_edge) else $error("bit off edge");

  c_update: cover property (@(posedge sys_clk_i) disable iff (!rstn_i) level_update_o);
  c_ack:    cover property (@(posedge sys_clk_i) disable iff (!rstn_i) $rose(line_oe_o));
  c_error:  cover property (@(posedge sys_clk_i) disable iff (!rstn_i) frame_error_o);
endmodule : ow_dim_receiver
`default_nettype wire

/* tb/host_model.sv */
// Purpose: Host side of the single-wire line: open-drain driver and pull-up
// Assumes: Driven on falling edges of sys_clk_i
// Notes:   A bit lasts 500 cycles times the scale s (100 kbit/s at s=1)
`timescale 1ns/1ps
`default_nettype none
module host_model (
  input  wire logic sys_clk_i,
  input  wire logic line_o,
  input  wire logic line_oe_o,
  output logic      line_i
);
  logic host_low = 1'b0;
  // Pulled high unless a party pulls it low
  assign line_i = ~(host_low | (line_oe_o & ~line_o));
  task automatic send_byte(input logic [7:0] b, input int s, bad);
    int lo;
    for (int i = 7; i >= 0; i--) begin
      lo = (i == bad) ? 250 * s : (b[i] ? 100 * s : 400 * s);
      host_low <= 1'b1;
      repeat (lo) @(negedge sys_clk_i);
      host_low <= 1'b0;
      repeat (500 * s - lo) @(negedge sys_clk_i);
    end
    // Last falling edge closes bit 0 and opens the end-of-stream low
    host_low <= 1'b1;
  endtask : send_byte
  task automatic send_frame(input logic [7:0] a, d, input int s, bad, input bit ack,
                            output int dly, output int len, output logic got);
    dly = 0;
    len = 0;
    got = 1'b0;
    // Line is already high, so the address byte needs no start condition
    send_byte(a, s, 8);
    repeat (200) @(negedge sys_clk_i);
    host_low <= 1'b0;
    repeat (200) @(negedge sys_clk_i);
    send_byte(d, s, bad);
    if (ack) begin
      // Held low through the delay until the pull-down takes over
      while (line_oe_o !== 1'b1 && dly < 1000) begin
        @(negedge sys_clk_i);
        dly++;
      end
      host_low <= 1'b0;
      @(negedge sys_clk_i);
      got = (line_i === 1'b0);
      len = 1;
      while (line_i !== 1'b1 && len < 46000) begin
        @(negedge sys_clk_i);
        len++;
      end
    end else begin
      repeat (200) @(negedge sys_clk_i);
      host_low <= 1'b0;
    end
    repeat (200) @(negedge sys_clk_i);
  endtask : send_frame
endmodule : host_model
`default_nettype wire

/* tb/testbench.sv */
// Purpose: Self-checking bench for the single-wire command receiver
// Assumes: Default device address; 50 MHz clock
// Notes:   Levels of the two random runs come from an LFSR seeded with 26
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import ow_dim_pkg::*;
  logic                sys_clk_i = 1'b0;
  logic                rstn_i    = 1'b0;
  wire logic           line_i;
  wire logic           line_o;
  wire logic           line_oe_o;
  wire logic           level_update_o;
  wire logic           frame_error_o;
  wire logic [LEVEL_W-1:0] feedback_reference_o;
  int                  err_count = 0;
  int                  compares  = 0;
  int                  upd_n     = 0;
  int                  ferr_n    = 0;
  int                  oe_n      = 0;
  int                  dly;
  int                  len;
  logic                got;
  logic [7:0]          rnd = 8'h1A;
  logic [LEVEL_W-1:0]  lvl = LEVEL_RESET;
  always #10 sys_clk_i = ~sys_clk_i;
  ow_dim_receiver #(.DEVICE_ADDR(DEVICE_ADDR_DEFAULT)) dut_u (
    .sys_clk_i(sys_clk_i), .rstn_i(rstn_i), .line_i(line_i), .line_o(line_o),
    .line_oe_o(line_oe_o), .feedback_reference_o(feedback_reference_o),
    .level_update_o(level_update_o), .frame_error_o(frame_error_o));
  host_model host_u (
    .sys_clk_i(sys_clk_i), .line_o(line_o), .line_oe_o(line_oe_o), .line_i(line_i));
  always @(posedge sys_clk_i) begin
    if (level_update_o === 1'b1) upd_n <= upd_n + 1;
    if (frame_error_o === 1'b1) ferr_n <= ferr_n + 1;
    if (line_oe_o === 1'b1) oe_n <= oe_n + 1;
  end
  function automatic logic [7:0] lfsr_next(input logic [7:0] x);
    return {x[6:0], x[7] ^ x[5] ^ x[4] ^ x[3]};
  endfunction : lfsr_next
  function automatic logic accept(input logic [7:0] a, d, input int bad);
    return a === DEVICE_ADDR_DEFAULT && d[6:5] === 2'b00 && bad == 8;
  endfunction : accept
  task automatic check(input logic [31:0] seen, exp);
    compares++;
    if (seen !== exp) begin
      err_count++;
      $display("wrong value at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask : check
  task automatic run(input string name, input logic [7:0] a, d, input int s, bad);
    logic ok;
    ok = accept(a, d, bad);
    upd_n = 0;
    ferr_n = 0;
    oe_n = 0;
    host_u.send_frame(a, d, s, bad, ok && d[7], dly, len, got);
    repeat (50) @(negedge sys_clk_i);
    if (ok) lvl = d[4:0];
    check(upd_n, ok);
    check(ferr_n != 0, !ok);
    check(feedback_reference_o, lvl);
    if (ok && d[7]) begin
      check(got, 1'b1);
      check(dly >= ACK_DELAY_CYCLES && dly <= ACK_DELAY_CYCLES + 8, 1'b1);
      check(len >= ACK_PULSE_CYCLES - 2 && len <= ACK_PULSE_CYCLES, 1'b1);
    end else begin
      check(oe_n, 0);
    end
    $display("test %s done", name);
  endtask : run
  task automatic wrap_up;
    $display("compares %0d mismatches %0d", compares, err_count);
    if (err_count == 0 && compares > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : wrap_up
  initial begin
    repeat (20) @(negedge sys_clk_i);
    rstn_i <= 1'b1;
    repeat (300) @(negedge sys_clk_i);
    check(feedback_reference_o, LEVEL_RESET);
    check(line_oe_o, 1'b0);
    check(line_o, 1'b0);
    for (int k = 1; k <= 2; k++) begin
      rnd = lfsr_next(rnd);
      run("random", DEVICE_ADDR_DEFAULT, {3'b000, rnd[4:0]}, k, 8);
    end
    run("ack", DEVICE_ADDR_DEFAULT, 8'h9F, 1, 8);
    run("addr_lsb", DEVICE_ADDR_DEFAULT ^ 8'h01, 8'h85, 1, 8);
    run("subaddr", DEVICE_ADDR_DEFAULT, 8'hA3, 1, 8);
    run("bad_bit", DEVICE_ADDR_DEFAULT, 8'h80, 1, 3);
    wrap_up();
  end
  initial begin
    repeat (120000) @(posedge sys_clk_i);
    err_count++;
    wrap_up();
  end
endmodule : testbench
`default_nettype wire
